// [pkg/iiac_cfg.svh]
`ifndef IIAC_CFG_SVH
`define IIAC_CFG_SVH

// Register indices on the model-register request port
`define IIAC_OFS_ACCESS_CTL   32'h0000_004e
`define IIAC_OFS_INV_NUMBER   32'h0000_004f
`define IIAC_OFS_PLAT_INFO    32'h0000_00ce

// Access control fields
`define IIAC_CTL_LOCK_BIT     0
`define IIAC_CTL_ENABLE_BIT   1
`define IIAC_CTL_RESET        2'h0
`define IIAC_CTL_READ_OPEN    2'h2

// Platform capability info fields
`define IIAC_INFO_RATIO_LSB   8
`define IIAC_INFO_RATIO_MSB   15
`define IIAC_INFO_CAP_BIT     23
`define IIAC_INFO_TURBO_BIT   28

// Settle count, reached two edges after reset release; fuse values are trusted from the third edge
`define IIAC_FUSE_SETTLE      2'h2

`endif

// [pkg/iiac_pkg.sv]
package iiac_pkg;

    // Access state is the pair {read enable, access_bit_a}
    typedef enum logic [1:0] {
        IIAC_OPEN_CLOSED = 2'b00,
        IIAC_LOCK_CLOSED = 2'b01,
        IIAC_OPEN_READ   = 2'b10,
        IIAC_LOCK_READ   = 2'b11
    } iiac_state_t;

endpackage

// [design/iiac_fuse_latch.sv]
`timescale 1ns/1ps
`default_nettype none
`include "iiac_cfg.svh"

module iiac_fuse_latch
#(
    parameter int WIDTH = 74
)
(
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] fuse_in,
    output logic      [WIDTH-1:0] fuse_val,
    output logic                  fuse_valid
);

    if (WIDTH < 1)
    begin : g_chk
        $error("iiac_fuse_latch: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] sync1_r;
    logic [WIDTH-1:0] sync2_r;
    logic [WIDTH-1:0] val_r;
    logic [WIDTH-1:0] val_nxt;
    logic [1:0]       cnt_r;
    logic [1:0]       cnt_nxt;
    logic             valid_r;
    logic             valid_nxt;

    // Fuse values are caught once, after the synchroniser has settled
    always_comb
    begin
        val_nxt   = val_r;
        cnt_nxt   = cnt_r;
        valid_nxt = valid_r;
        if (!valid_r)
        begin
            if (cnt_r == `IIAC_FUSE_SETTLE)
            begin
                val_nxt   = sync2_r;
                valid_nxt = 1'b1;
            end
            else
            begin
                cnt_nxt = cnt_r + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            val_r   <= '0;
            cnt_r   <= 2'h0;
            valid_r <= 1'b0;
        end
        else
        begin
            sync1_r <= fuse_in;
            sync2_r <= sync1_r;
            val_r   <= val_nxt;
            cnt_r   <= cnt_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign fuse_val   = val_r;
    assign fuse_valid = valid_r;

endmodule // iiac_fuse_latch
`default_nettype wire

// [design/iiac_top.sv]
// Functional notes
// RULE1: Access_bit_a set blocks further control writes
// RULE2: Access_bit_a may set only while enable clear
// RULE3: Both control bits reset to zero
// RULE4: Enable set allows inventory number read; code allows it only at 10b and faults the read at 11b
// RULE5: Access_bit_a write with enable set faults; code faults only while access_bit_a clear, ignores it at 11b
// RULE6: Inventory read with enable clear faults
// RULE7: Inventory number is read-only, unique 64-bit
// RULE8: Inventory access only when control equals 10b
// RULE9: Info bits 15:8 give non-turbo ratio
// RULE10: Info bit 23 reports inventory capability
// RULE11: No capability: both inventory registers fault
// RULE12: Info bit 28 reports programmable turbo limits
// RULE13: Agent should write 01b after reading
// RULE14: Firmware should ask user before enabling
// RULE15: Reserved bits read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "iiac_cfg.svh"

module iiac_top
    import iiac_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        msr_req,
    input  wire logic        msr_wr,
    input  wire logic [31:0] msr_addr,
    input  wire logic [63:0] msr_wdata,
    input  wire logic [63:0] fuse_inventory_number,
    input  wire logic [7:0]  fuse_non_turbo_ratio,
    input  wire logic        fuse_inventory_capable,
    input  wire logic        fuse_turbo_prog,
    output logic             msr_ready,
    output logic             msr_ack,
    output logic             general_protection_fault,
    output logic             msr_miss,
    output logic [63:0]      msr_rdata,
    output logic             inventory_read_enable,
    output logic             access_bit_a
);

    localparam int FUSE_W = 74;

    logic [FUSE_W-1:0] fuse_val;
    logic              fuse_valid;
    logic [63:0]       inventory_number;
    logic [7:0]        ratio;
    logic              cap;
    logic              turbo;

    // Inventory number and capabilities are fixed per package
    iiac_fuse_latch #(
        .WIDTH      (FUSE_W)
    ) u_fuse (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .fuse_in    ({fuse_turbo_prog, fuse_inventory_capable,
                      fuse_non_turbo_ratio, fuse_inventory_number}),
        .fuse_val   (fuse_val),
        .fuse_valid (fuse_valid)
    );

    assign inventory_number = fuse_val[63:0];                  // [RULE7]
    assign ratio            = fuse_val[71:64];
    assign cap              = fuse_val[72];
    assign turbo            = fuse_val[73];

    iiac_state_t state_r;
    iiac_state_t state_nxt;
    logic        ack_r;
    logic        ack_nxt;
    logic        fault_r;
    logic        fault_nxt;
    logic        miss_r;
    logic        miss_nxt;
    logic [63:0] rdata_r;
    logic [63:0] rdata_nxt;
    logic        ready_r;
    logic        take;
    logic        hit_ctl;
    logic        hit_num;
    logic        hit_info;
    logic        lock_now;
    logic        en_now;
    logic [63:0] info_word;
    logic [63:0] ctl_word;

    assign take     = msr_req && fuse_valid && !ack_r;
    assign hit_ctl  = (msr_addr == `IIAC_OFS_ACCESS_CTL);
    assign hit_num  = (msr_addr == `IIAC_OFS_INV_NUMBER);
    assign hit_info = (msr_addr == `IIAC_OFS_PLAT_INFO);
    assign lock_now = state_r[`IIAC_CTL_LOCK_BIT];
    assign en_now   = state_r[`IIAC_CTL_ENABLE_BIT];

    // Reserved fields read as zero
    always_comb
    begin
        info_word = 64'(ratio) << `IIAC_INFO_RATIO_LSB; // [RULE9] [RULE15]
        info_word[`IIAC_INFO_CAP_BIT]   = cap;                 // [RULE10]
        info_word[`IIAC_INFO_TURBO_BIT] = turbo;               // [RULE12]
        ctl_word = {62'h0, state_r};                           // [RULE15]
    end

    always_comb
    begin
        state_nxt = state_r;
        ack_nxt   = 1'b0;
        fault_nxt = fault_r;
        miss_nxt  = miss_r;
        rdata_nxt = rdata_r;
        if (take)
        begin
            ack_nxt   = 1'b1;
            fault_nxt = 1'b0;
            miss_nxt  = 1'b0;
            rdata_nxt = 64'h0;
            if ((hit_ctl || hit_num) && !cap)
            begin
                fault_nxt = 1'b1;                              // [RULE11]
            end
            else if (hit_ctl && msr_wr)
            begin
                if (lock_now)
                begin
                    state_nxt = state_r;                       // [RULE1]
                end
                else if (msr_wdata[`IIAC_CTL_LOCK_BIT] && en_now)
                begin
                    fault_nxt = 1'b1;                      // [RULE2] [RULE5]
                end
                else
                begin
                    state_nxt = iiac_state_t'(msr_wdata[1:0]); // [RULE15]
                end
            end
            else if (hit_ctl)
            begin
                rdata_nxt = ctl_word;
            end
            else if (hit_num && !msr_wr
                     && state_r == `IIAC_CTL_READ_OPEN)
            begin
                rdata_nxt = inventory_number;              // [RULE4] [RULE8]
            end
            else if (hit_num)
            begin
                fault_nxt = 1'b1;                          // [RULE6] [RULE7]
            end
            else if (hit_info)
            begin
                if (msr_wr)
                begin
                    fault_nxt = 1'b1;
                end
                else
                begin
                    rdata_nxt = info_word;
                end
            end
            else
            begin
                miss_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= IIAC_OPEN_CLOSED;                       // [RULE3]
            ack_r   <= 1'b0;
            fault_r <= 1'b0;
            miss_r  <= 1'b0;
            rdata_r <= 64'h0;
            ready_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            ack_r   <= ack_nxt;
            fault_r <= fault_nxt;
            miss_r  <= miss_nxt;
            rdata_r <= rdata_nxt;
            ready_r <= fuse_valid;
        end
    end

    assign msr_ready                = ready_r;
    assign msr_ack                  = ack_r;
    assign general_protection_fault = fault_r;
    assign msr_miss                 = miss_r;
    assign msr_rdata                = rdata_r;
    assign inventory_read_enable    = state_r[`IIAC_CTL_ENABLE_BIT];
    assign access_bit_a             = state_r[`IIAC_CTL_LOCK_BIT];

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    reset_ctl_a: assert property ( // [RULE3]
        !fuse_valid |-> state_r == IIAC_OPEN_CLOSED)
        else $error("control not zero before first access");

    lock_hold_a: assert property ( // [RULE1]
        access_bit_a |=> access_bit_a && $stable(state_r))
        else $error("locked control register changed");

    lock_gate_a: assert property ( // [RULE2]
        $rose(access_bit_a) |-> !$past(inventory_read_enable))
        else $error("access_bit_a set while read enable was set");

    lock_fault_a: assert property ( // [RULE5]
        take && msr_wr && hit_ctl && cap && !lock_now && en_now
        && msr_wdata[0] |=> msr_ack && general_protection_fault
        && $stable(state_r))
        else $error("access_bit_a write with enable did not fault");

    rd_closed_a: assert property ( // [RULE6]
        take && !msr_wr && hit_num && !en_now
        |=> msr_ack && general_protection_fault)
        else $error("inventory read with enable clear did not fault");

    rd_open_a: assert property ( // [RULE8]
        take && !msr_wr && hit_num && cap
        && state_r == IIAC_OPEN_READ |=> msr_ack
        && !general_protection_fault
        && msr_rdata == $past(inventory_number))
        else $error("permitted inventory read failed");

    num_ro_a: assert property ( // [RULE7]
        take && msr_wr && hit_num |=> general_protection_fault
        && $stable(state_r))
        else $error("inventory number write not refused");

    no_cap_a: assert property ( // [RULE11]
        take && (hit_ctl || hit_num) && !cap
        |=> msr_ack && general_protection_fault && $stable(state_r))
        else $error("access without capability did not fault");

    info_rd_a: assert property ( // [RULE9]
        take && !msr_wr && hit_info |=> !general_protection_fault
        && msr_rdata[15:8] == $past(ratio)
        && msr_rdata[23] == $past(cap)
        && msr_rdata[28] == $past(turbo)
        && msr_rdata[7:0] == 8'h00 && msr_rdata[63:29] == 35'h0)
        else $error("platform info read wrong");

    ack_pulse_a: assert property (
        msr_ack |=> !msr_ack)
        else $error("acknowledge longer than one cycle");

    read_ok_c: cover property (
        msr_ack && !general_protection_fault && inventory_read_enable
        && !access_bit_a);
    lock_after_c: cover property (
        !access_bit_a && inventory_read_enable
        ##[1:20] access_bit_a && !inventory_read_enable);
    lock_fault_c: cover property (
        msr_ack && general_protection_fault && inventory_read_enable);

endmodule // iiac_top
`default_nettype wire

// [verif/tb_iiac_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "iiac_cfg.svh"

module tb_iiac_top;

    logic        core_clk;
    logic        nrst;
    logic        msr_req;
    logic        msr_wr;
    logic [31:0] msr_addr;
    logic [63:0] msr_wdata;
    logic [63:0] fuse_num;
    logic [7:0]  fuse_ratio;
    logic        fuse_cap;
    logic        fuse_turbo;
    wire  logic  msr_ready;
    wire  logic  msr_ack;
    wire  logic  gp_fault;
    wire  logic  msr_miss;
    wire  logic [63:0] msr_rdata;
    wire  logic  rd_en;
    wire  logic  lock_bit;
    wire  logic [63:0] info_exp;
    logic [63:0] got_rd;
    logic        got_f;
    logic        got_m;
    int          num_errors;
    int          num_checks;

    assign info_exp = {35'h0, fuse_turbo, 4'h0, fuse_cap, 7'h0,
                       fuse_ratio, 8'h0};

    iiac_top u_dut
    (
        .core_clk                 (core_clk),
        .nrst                     (nrst),
        .msr_req                  (msr_req),
        .msr_wr                   (msr_wr),
        .msr_addr                 (msr_addr),
        .msr_wdata                (msr_wdata),
        .fuse_inventory_number    (fuse_num),
        .fuse_non_turbo_ratio     (fuse_ratio),
        .fuse_inventory_capable   (fuse_cap),
        .fuse_turbo_prog          (fuse_turbo),
        .msr_ready                (msr_ready),
        .msr_ack                  (msr_ack),
        .general_protection_fault (gp_fault),
        .msr_miss                 (msr_miss),
        .msr_rdata                (msr_rdata),
        .inventory_read_enable    (rd_en),
        .access_bit_a             (lock_bit)
    );

    always #25 core_clk = ~core_clk;

    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] got,
                       input logic [63:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
            num_errors++;
        end
    endtask

    // Holds the request until the edge that samples ack high
    task automatic access(input logic w, input logic [31:0] a,
                          input logic [63:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        msr_req   <= 1'b1;
        msr_wr    <= w;
        msr_addr  <= a;
        msr_wdata <= d;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (msr_ack !== 1'b1 && n < 40);
        msr_req <= 1'b0;
        got_rd = msr_rdata;
        got_f  = gp_fault;
        got_m  = msr_miss;
        if (n >= 40)
        begin
            $display("MISMATCH ack exp 1 got timeout");
            num_errors++;
            final_report();
        end
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [63:0] d,
                          input logic f);
        access(1'b0, a, d);
        chk("rdata", got_rd, d);
        chk("fault", {63'h0, got_f}, {63'h0, f});
    endtask

    task automatic wr_chk(input logic [31:0] a, input logic [63:0] d,
                          input logic f);
        access(1'b1, a, d);
        chk("wr_fault", {63'h0, got_f}, {63'h0, f});
    endtask

    task automatic do_reset(input logic cap, input logic turbo);
        @(posedge core_clk);
        nrst       <= 1'b0;
        fuse_cap   <= cap;
        fuse_turbo <= turbo;
        repeat (4) @(posedge core_clk);
        chk("ready_rst", {63'h0, msr_ready}, 64'h0);
        nrst <= 1'b1;
    endtask

    initial
    begin
        core_clk   = 1'b0;
        nrst       = 1'b0;
        msr_req    = 1'b0;
        msr_wr     = 1'b0;
        msr_addr   = 32'h0;
        msr_wdata  = 64'h0;
        fuse_num   = 64'h0123_4567_89ab_cdef;
        fuse_ratio = 8'h1c;
        fuse_cap   = 1'b1;
        fuse_turbo = 1'b1;
        num_errors = 0;
        num_checks = 0;
        do_reset(1'b1, 1'b1);
        rd_chk(`IIAC_OFS_ACCESS_CTL, 64'h0, 1'b0);
        chk("enable_pin", {63'h0, rd_en}, 64'h0);
        chk("ready", {63'h0, msr_ready}, 64'h1);
        rd_chk(`IIAC_OFS_INV_NUMBER, 64'h0, 1'b1);
        rd_chk(`IIAC_OFS_PLAT_INFO, info_exp, 1'b0);
        wr_chk(`IIAC_OFS_PLAT_INFO, '1, 1'b1);
        wr_chk(`IIAC_OFS_INV_NUMBER, '1, 1'b1);
        rd_chk(`IIAC_OFS_PLAT_INFO, info_exp, 1'b0);
        // Reserved bits set, lock bit clear, enable set
        wr_chk(`IIAC_OFS_ACCESS_CTL, ~64'h1, 1'b0);
        rd_chk(`IIAC_OFS_ACCESS_CTL, 64'h2, 1'b0);
        chk("enable_pin", {63'h0, rd_en}, 64'h1);
        rd_chk(`IIAC_OFS_INV_NUMBER, fuse_num, 1'b0);
        rd_chk(`IIAC_OFS_INV_NUMBER, fuse_num, 1'b0);
        wr_chk(`IIAC_OFS_ACCESS_CTL, 64'h3, 1'b1);
        rd_chk(`IIAC_OFS_ACCESS_CTL, 64'h2, 1'b0);
        access(1'b0, 32'h0000_0010, 64'h0);
        chk("miss", {63'h0, got_m}, 64'h1);
        wr_chk(`IIAC_OFS_ACCESS_CTL, 64'h0, 1'b0);
        wr_chk(`IIAC_OFS_ACCESS_CTL, 64'h1, 1'b0);
        chk("lock_pin", {63'h0, lock_bit}, 64'h1);
        rd_chk(`IIAC_OFS_INV_NUMBER, 64'h0, 1'b1);
        wr_chk(`IIAC_OFS_ACCESS_CTL, 64'h2, 1'b0);
        rd_chk(`IIAC_OFS_ACCESS_CTL, 64'h1, 1'b0);
        do_reset(1'b1, 1'b0);
        rd_chk(`IIAC_OFS_ACCESS_CTL, 64'h0, 1'b0);
        rd_chk(`IIAC_OFS_PLAT_INFO, info_exp, 1'b0);
        wr_chk(`IIAC_OFS_ACCESS_CTL, 64'h3, 1'b0);
        rd_chk(`IIAC_OFS_INV_NUMBER, 64'h0, 1'b1);
        do_reset(1'b0, 1'b1);
        rd_chk(`IIAC_OFS_PLAT_INFO, info_exp, 1'b0);
        rd_chk(`IIAC_OFS_ACCESS_CTL, 64'h0, 1'b1);
        wr_chk(`IIAC_OFS_ACCESS_CTL, 64'h2, 1'b1);
        rd_chk(`IIAC_OFS_INV_NUMBER, 64'h0, 1'b1);
        chk("enable_pin", {63'h0, rd_en}, 64'h0);
        final_report();
    end

endmodule // tb_iiac_top
`default_nettype wire
